// ==== src/smd_ctl.sv ====
// What this block does
// - dual loop: position from secondary encoder
// - dual loop: error limits use secondary
// - entering dual loop loads target
// - ssi source used when dual selected
// - code 243 selects dual loop
// - driver off blocks motion until enabled
// - code 228 disables the driver
// - mode 27 shorts windings when off and hw_enable_in is high
// - mapping reserves registers 25 to 37
// - mapping takes start, timeout, 1-6 maps
// - code 226 stops trajectory at once
// - done waits for empty queue
// - monitor drives a, b, index lines
// - monitor output conflicts raise error
// - invert lines 1-3 for differential
// - monitor stays until its off command
`timescale 1ns/100ps
`include "smd_params.svh"
module smd_ctl
    import smd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // command link
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] map_start_in,
    input wire logic [31:0] map_timeout_in,
    input wire logic [2:0] map_count_in,
    input wire logic mode27_in,
    output logic ack_out,
    output logic cmd_err_out,
    output logic prog_abort_out,
    // feedback
    input wire logic [31:0] pri_pos_in,
    input wire logic [31:0] sec_pos_in,
    input wire logic [31:0] ssi_pos_in,
    input wire logic ssi_dual_src_in,
    input wire logic hw_enable_in,
    output logic dual_loop_out,
    output logic [31:0] loop_pos_out,
    output logic [31:0] limit_pos_out,
    output logic [31:0] comm_pos_out,
    output logic target_load_out,
    output logic [31:0] target_val_out,
    // driver and motion
    input wire logic motor_const_set_in,
    input wire logic motion_req_in,
    output logic drv_off_out,
    output logic motion_go_out,
    output logic short_wind_out,
    output logic traj_stop_out,
    output logic multitask_out,
    // mapping
    output logic map_active_out,
    output logic [7:0] map_start_out,
    output logic [31:0] map_timeout_out,
    output logic [2:0] map_count_out,
    output logic [7:0] rsv_lo_out,
    output logic [7:0] rsv_hi_out,
    output logic tick_out,
    // done and encoder monitor
    input wire logic queue_empty_in,
    input wire logic motion_active_in,
    input wire logic err_ok_in,
    input wire logic [2:0] io_is_out_in,
    input wire logic io_bit_wr_in,
    input wire logic [1:0] io_bit_line_in,
    input wire logic diff_out_in,
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic enc_z_in,
    output logic [2:0] io_drive_out,
    output logic [2:0] io_val_out,
    output logic led_green_out
);
    default clocking smd_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    logic cmd_dual, cmd_drv_off, cmd_mt_off, cmd_mon_on, cmd_map;
    logic known_r, map_ok, mon_conflict, bit_conflict;
    logic dual_r, drv_off_r, mon_r, idle, inv;
    logic [16:0] tick_cnt_r;
    smd_done_e done_r;
    assign cmd_dual = cmd_valid_in && cmd_code_in == `SMD_CMD_DUAL_LOOP;
    assign cmd_drv_off = cmd_valid_in && cmd_code_in == `SMD_CMD_DRV_OFF;
    assign cmd_mt_off = cmd_valid_in && cmd_code_in == `SMD_CMD_MT_OFF;
    assign cmd_mon_on = cmd_valid_in && cmd_code_in == `SMD_CMD_MON_ON;
    assign cmd_map = cmd_valid_in && cmd_code_in == `SMD_CMD_MAP;
    assign map_ok = map_count_in >= `SMD_MAP_MIN &&
        map_count_in <= `SMD_MAP_MAX;
    assign mon_conflict = cmd_mon_on && (|io_is_out_in);
    assign bit_conflict = mon_r && io_bit_wr_in && io_bit_line_in != 2'd0;
    assign idle = queue_empty_in && !motion_active_in && err_ok_in;
    assign inv = diff_out_in;
    always_comb begin
        unique case (cmd_code_in)
            `SMD_CMD_DUAL_LOOP, `SMD_CMD_SINGLE_LOOP, `SMD_CMD_DRV_OFF,
            `SMD_CMD_DRV_ON, `SMD_CMD_MOTOR_CONST, `SMD_CMD_MT_OFF,
            `SMD_CMD_MT_ON, `SMD_CMD_DONE_HIGH, `SMD_CMD_DONE_LOW,
            `SMD_CMD_DONE_OFF, `SMD_CMD_MON_ON, `SMD_CMD_MON_OFF,
            `SMD_CMD_MAP_OFF: known_r = 1'b1;
            `SMD_CMD_MAP: known_r = map_ok;
            default: known_r = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ack_out <= 1'b0;
            cmd_err_out <= 1'b0;
            prog_abort_out <= 1'b0;
        end else begin
            ack_out <= cmd_valid_in && known_r && !mon_conflict;
            cmd_err_out <= (cmd_valid_in && !known_r) || mon_conflict ||
                bit_conflict;
            prog_abort_out <= mon_conflict || bit_conflict;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            dual_r <= 1'b0;
        end else if (cmd_dual) begin
            dual_r <= 1'b1;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_SINGLE_LOOP) begin
            dual_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            dual_loop_out <= 1'b0;
            loop_pos_out <= 32'h0000_0000;
            limit_pos_out <= 32'h0000_0000;
            comm_pos_out <= 32'h0000_0000;
        end else begin
            dual_loop_out <= dual_r;
            comm_pos_out <= pri_pos_in;
            if (dual_r) begin
                loop_pos_out <= ssi_dual_src_in ? ssi_pos_in : sec_pos_in;
                limit_pos_out <= ssi_dual_src_in ? ssi_pos_in : sec_pos_in;
            end else begin
                loop_pos_out <= pri_pos_in;
                limit_pos_out <= pri_pos_in;
            end
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            target_load_out <= 1'b0;
            target_val_out <= 32'h0000_0000;
        end else begin
            target_load_out <= cmd_dual && !dual_r;
            if (cmd_dual && !dual_r) begin
                target_val_out <= ssi_dual_src_in ? ssi_pos_in : sec_pos_in;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            drv_off_r <= 1'b0;
        end else if (cmd_drv_off) begin
            drv_off_r <= 1'b1;
        end else if (cmd_valid_in && (cmd_code_in == `SMD_CMD_MOTOR_CONST ||
            (cmd_code_in == `SMD_CMD_DRV_ON && motor_const_set_in))) begin
            drv_off_r <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            drv_off_out <= 1'b0;
            motion_go_out <= 1'b0;
            short_wind_out <= 1'b0;
        end else begin
            drv_off_out <= drv_off_r;
            motion_go_out <= motion_req_in && !drv_off_r && !cmd_drv_off;
            short_wind_out <= mode27_in && drv_off_r && hw_enable_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            traj_stop_out <= 1'b0;
            multitask_out <= 1'b0;
        end else begin
            traj_stop_out <= cmd_mt_off;
            if (cmd_mt_off) begin
                multitask_out <= 1'b0;
            end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_MT_ON) begin
                multitask_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            map_active_out <= 1'b0;
            map_start_out <= `SMD_START_DEFAULT;
            map_timeout_out <= 32'h0000_0000;
            map_count_out <= `SMD_MAP_MIN;
        end else if (cmd_map && map_ok) begin
            map_active_out <= 1'b1;
            map_start_out <= map_start_in;
            map_timeout_out <= map_timeout_in;
            map_count_out <= map_count_in;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_MAP_OFF) begin
            map_active_out <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rsv_lo_out <= 8'h00;
            rsv_hi_out <= 8'h00;
        end else begin
            rsv_lo_out <= map_active_out ? `SMD_RSV_LO : 8'h00;
            rsv_hi_out <= map_active_out ? `SMD_RSV_HI : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tick_cnt_r <= 17'h0_0000;
            tick_out <= 1'b0;
        end else if (tick_cnt_r == 17'(`SMD_TICK_CYC - 1)) begin
            tick_cnt_r <= 17'h0_0000;
            tick_out <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 17'h0_0001;
            tick_out <= 1'b0;
        end
    end

    // done mode select
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            done_r <= SMD_DONE_OFF;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_DONE_HIGH) begin
            done_r <= SMD_DONE_HI;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_DONE_LOW) begin
            done_r <= SMD_DONE_LO;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_DONE_OFF) begin
            done_r <= SMD_DONE_OFF;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mon_r <= 1'b0;
        end else if (cmd_mon_on && !mon_conflict) begin
            mon_r <= 1'b1;
        end else if (cmd_valid_in && cmd_code_in == `SMD_CMD_MON_OFF) begin
            mon_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            io_drive_out <= 3'b000;
            io_val_out <= 3'b000;
            led_green_out <= 1'b0;
        end else begin
            led_green_out <= done_r != SMD_DONE_OFF && idle;
            if (mon_r) begin
                io_drive_out <= 3'b111;
                io_val_out <= {enc_z_in, enc_b_in, enc_a_in} ^ {3{inv}};
            end else begin
                io_drive_out <= {2'b00, done_r != SMD_DONE_OFF};
                unique case (done_r)
                    SMD_DONE_HI: io_val_out <= {2'b00, idle};
                    SMD_DONE_LO: io_val_out <= {2'b00, !idle};
                    default: io_val_out <= 3'b000;
                endcase
            end
        end
    end
    chk_done_busy: assert property (
        !queue_empty_in && done_r == SMD_DONE_HI |=> !led_green_out)
        else $error("done shown while queue busy");
    chk_drv_off_cmd: assert property (
        cmd_drv_off |=> ##1 drv_off_out)
        else $error("driver not disabled");
    chk_no_motion: assert property (
        drv_off_r |=> !motion_go_out)
        else $error("motion while driver off");
    chk_traj_stop: assert property (
        cmd_mt_off |=> traj_stop_out && !multitask_out)
        else $error("trajectory not stopped");
    chk_target_load: assert property (
        cmd_dual && !dual_r && !ssi_dual_src_in |=>
        target_load_out && target_val_out == $past(sec_pos_in))
        else $error("target not loaded");
    chk_dual_route: assert property (
        dual_r && !ssi_dual_src_in |=> loop_pos_out == $past(sec_pos_in) &&
        comm_pos_out == $past(pri_pos_in))
        else $error("dual loop routing wrong");
    chk_conflict: assert property (
        mon_conflict |=> cmd_err_out && prog_abort_out && !ack_out)
        else $error("conflict not flagged");
    chk_short: assert property (
        mode27_in && drv_off_r && hw_enable_in |=> short_wind_out)
        else $error("windings not shorted");
    chk_reserve: assert property (
        map_active_out |=>
        rsv_lo_out == `SMD_RSV_LO && rsv_hi_out == `SMD_RSV_HI)
        else $error("reserve window wrong");
endmodule

// ==== pkg/smd_params.svh ====
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH
// command codes
`define SMD_CMD_DUAL_LOOP 8'hF3
`define SMD_CMD_SINGLE_LOOP 8'hF4
`define SMD_CMD_DRV_OFF 8'hE4
`define SMD_CMD_DRV_ON 8'hE3
`define SMD_CMD_MOTOR_CONST 8'hA8
`define SMD_CMD_MT_OFF 8'hE2
`define SMD_CMD_MT_ON 8'hE7
`define SMD_CMD_DONE_HIGH 8'hFB
`define SMD_CMD_DONE_LOW 8'hBB
`define SMD_CMD_DONE_OFF 8'hAB
`define SMD_CMD_MON_ON 8'hAA
`define SMD_CMD_MON_OFF 8'hAC
`define SMD_CMD_MAP 8'hC8
`define SMD_CMD_MAP_OFF 8'hC9
// mapping limits
`define SMD_MAP_MIN 3'd1
`define SMD_MAP_MAX 3'd6
`define SMD_START_DEFAULT 8'h00
`define SMD_RSV_LO 8'd25
`define SMD_RSV_HI 8'd37
// tick timing
`define SMD_TICK_NS 120000
`define SMD_CLK_NS 10
`define SMD_TICK_CYC (`SMD_TICK_NS / `SMD_CLK_NS)
`endif

// ==== pkg/smd_pkg.sv ====
package smd_pkg;
    typedef enum logic [1:0] {
        SMD_ANS_ACK = 2'b01,
        SMD_ANS_ERR = 2'b10
    } smd_ans_e;
    typedef logic [31:0] smd_word_t;
    typedef enum logic [2:0] {
        SMD_DONE_OFF = 3'b001,
        SMD_DONE_HI = 3'b010,
        SMD_DONE_LO = 3'b100
    } smd_done_e;
endpackage

// ==== verif/smd_host.sv ====
`timescale 1ns/100ps
module smd_host (
    // clock
    input wire logic sys_clk_in,
    // command link
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out
);
    initial begin
        cmd_valid_out = 1'h0;
        cmd_code_out = 8'h00;
    end
    // link rate preset
    // the link is taken as already running at the lighting rate
    // one word codes
    // each code is a single word with no parameter words after it
    task automatic send(input logic [7:0] code);
        @(negedge sys_clk_in);
        cmd_valid_out = 1'h1;
        cmd_code_out = code;
        @(negedge sys_clk_in);
        cmd_valid_out = 1'h0;
        cmd_code_out = ~code;
    endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`include "smd_params.svh"
module tb;
    import smd_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic [4:0] exp;
    } smd_row_s;
    logic sys_clk_in, reset_in, cmd_valid_in, mode27_in, ssi_dual_src_in;
    logic hw_enable_in, motor_const_set_in, motion_req_in, queue_empty_in;
    logic motion_active_in, err_ok_in, io_bit_wr_in, diff_out_in;
    logic enc_a_in, enc_b_in, enc_z_in;
    logic [7:0] cmd_code_in, map_start_in;
    logic [31:0] map_timeout_in, pri_pos_in, sec_pos_in, ssi_pos_in;
    logic [2:0] map_count_in, io_is_out_in;
    logic [1:0] io_bit_line_in;
    logic ack_out, cmd_err_out, prog_abort_out, dual_loop_out;
    logic target_load_out, drv_off_out, motion_go_out, short_wind_out;
    logic traj_stop_out, multitask_out, map_active_out, tick_out;
    logic led_green_out;
    logic [31:0] loop_pos_out, limit_pos_out, comm_pos_out, target_val_out;
    logic [31:0] map_timeout_out;
    logic [7:0] map_start_out, rsv_lo_out, rsv_hi_out;
    logic [2:0] map_count_out, io_drive_out, io_val_out;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    // exp holds ack, err, dual loop, driver off, multitask
    smd_row_s rows [13] = '{
        '{8'hF3, 5'h14}, '{8'hE7, 5'h15}, '{8'hE2, 5'h14}, '{8'hE4, 5'h16},
        '{8'hE3, 5'h16}, '{8'hA8, 5'h14}, '{8'hF4, 5'h10}, '{8'hFB, 5'h10},
        '{8'hBB, 5'h10}, '{8'hAB, 5'h10}, '{8'hAC, 5'h10}, '{8'hC9, 5'h10},
        '{8'h00, 5'h08}};

    smd_ctl dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
        .map_start_in(map_start_in), .map_timeout_in(map_timeout_in),
        .map_count_in(map_count_in), .mode27_in(mode27_in),
        .ack_out(ack_out), .cmd_err_out(cmd_err_out),
        .prog_abort_out(prog_abort_out), .pri_pos_in(pri_pos_in),
        .sec_pos_in(sec_pos_in), .ssi_pos_in(ssi_pos_in),
        .ssi_dual_src_in(ssi_dual_src_in), .hw_enable_in(hw_enable_in),
        .dual_loop_out(dual_loop_out), .loop_pos_out(loop_pos_out),
        .limit_pos_out(limit_pos_out), .comm_pos_out(comm_pos_out),
        .target_load_out(target_load_out), .target_val_out(target_val_out),
        .motor_const_set_in(motor_const_set_in),
        .motion_req_in(motion_req_in), .drv_off_out(drv_off_out),
        .motion_go_out(motion_go_out), .short_wind_out(short_wind_out),
        .traj_stop_out(traj_stop_out), .multitask_out(multitask_out),
        .map_active_out(map_active_out), .map_start_out(map_start_out),
        .map_timeout_out(map_timeout_out), .map_count_out(map_count_out),
        .rsv_lo_out(rsv_lo_out), .rsv_hi_out(rsv_hi_out),
        .tick_out(tick_out), .queue_empty_in(queue_empty_in),
        .motion_active_in(motion_active_in), .err_ok_in(err_ok_in),
        .io_is_out_in(io_is_out_in), .io_bit_wr_in(io_bit_wr_in),
        .io_bit_line_in(io_bit_line_in), .diff_out_in(diff_out_in),
        .enc_a_in(enc_a_in), .enc_b_in(enc_b_in), .enc_z_in(enc_z_in),
        .io_drive_out(io_drive_out), .io_val_out(io_val_out),
        .led_green_out(led_green_out)
    );
    smd_host host (
        .sys_clk_in(sys_clk_in),
        .cmd_valid_out(cmd_valid_in),
        .cmd_code_out(cmd_code_in)
    );

    initial begin
        sys_clk_in = 1'h0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge sys_clk_in);
    endtask

    task automatic cmd(input logic [7:0] code, input logic ack,
                       input logic err);
        host.send(code);
        check(ack_out, ack);
        check(cmd_err_out, err);
    endtask

    task automatic wait_tick();
        n = 0;
        while (tick_out !== 1'h1) begin
            step(1);
            n++;
            if (n > 13000) begin
                fail_count++;
                final_report();
            end
        end
    endtask

    initial begin
        {reset_in, mode27_in, ssi_dual_src_in, hw_enable_in,
         motor_const_set_in, motion_req_in, queue_empty_in,
         motion_active_in, err_ok_in, io_bit_wr_in, diff_out_in, enc_a_in,
         enc_b_in, enc_z_in, io_bit_line_in, io_is_out_in} = '0;
        map_start_in = 8'h00;
        map_timeout_in = 32'h0000_0000;
        map_count_in = 3'h1;
        pri_pos_in = 32'h1111_1111;
        sec_pos_in = 32'h2222_2222;
        ssi_pos_in = 32'h3333_3333;
        reset_in = 1'h1;
        step(5);
        reset_in = 1'h0;
        check({dual_loop_out, drv_off_out, multitask_out}, 3'h0);
        check({map_active_out, map_count_out}, 32'h0000_0001);
        foreach (rows[i]) begin
            cmd(rows[i].code, rows[i].exp[4], rows[i].exp[3]);
            step(1);
            check(dual_loop_out, rows[i].exp[2]);
            check(drv_off_out, rows[i].exp[1]);
            check(multitask_out, rows[i].exp[0]);
        end
        host.send(`SMD_CMD_DUAL_LOOP);
        check(target_load_out, 1'h1);
        check(target_val_out, sec_pos_in);
        step(1);
        check(target_load_out, 1'h0);
        check(loop_pos_out, sec_pos_in);
        check(comm_pos_out, pri_pos_in);
        check(limit_pos_out, sec_pos_in);
        cmd(`SMD_CMD_SINGLE_LOOP, 1'h1, 1'h0);
        ssi_dual_src_in = 1'h1;
        cmd(`SMD_CMD_DUAL_LOOP, 1'h1, 1'h0);
        step(1);
        check(loop_pos_out, ssi_pos_in);
        motion_req_in = 1'h1;
        hw_enable_in = 1'h1;
        mode27_in = 1'h1;
        step(2);
        check({motion_go_out, short_wind_out}, 32'h0000_0002);
        cmd(`SMD_CMD_DRV_OFF, 1'h1, 1'h0);
        step(2);
        check(motion_go_out, 1'h0);
        check(short_wind_out, 1'h1);
        hw_enable_in = 1'h0;
        step(2);
        check(short_wind_out, 1'h0);
        motor_const_set_in = 1'h1;
        cmd(`SMD_CMD_DRV_ON, 1'h1, 1'h0);
        step(2);
        check({drv_off_out, motion_go_out}, 32'h0000_0001);
        cmd(`SMD_CMD_MT_ON, 1'h1, 1'h0);
        host.send(`SMD_CMD_MT_OFF);
        check(traj_stop_out, 1'h1);
        map_start_in = 8'h5A;
        map_timeout_in = 32'h0001_2345;
        map_count_in = 3'h7;
        cmd(`SMD_CMD_MAP, 1'h0, 1'h1);
        map_count_in = 3'h0;
        cmd(`SMD_CMD_MAP, 1'h0, 1'h1);
        map_count_in = 3'h6;
        cmd(`SMD_CMD_MAP, 1'h1, 1'h0);
        step(1);
        check({map_active_out, map_start_out, map_count_out},
              {1'h1, 8'h5A, 3'h6});
        check(map_timeout_out, 32'h0001_2345);
        check({rsv_lo_out, rsv_hi_out}, 32'h0000_1925);
        map_count_in = 3'h1;
        cmd(`SMD_CMD_MAP, 1'h1, 1'h0);
        step(1);
        check(map_count_out, 3'h1);
        cmd(`SMD_CMD_MAP_OFF, 1'h1, 1'h0);
        step(1);
        check({map_active_out, rsv_lo_out, rsv_hi_out}, 32'h0);
        wait_tick();
        step(1);
        wait_tick();
        check(n + 1, 32'h0000_2EE0);
        queue_empty_in = 1'h1;
        err_ok_in = 1'h1;
        cmd(`SMD_CMD_DONE_HIGH, 1'h1, 1'h0);
        step(2);
        check({io_val_out[0], led_green_out}, 2'h3);
        queue_empty_in = 1'h0;
        step(2);
        check({io_val_out[0], led_green_out}, 2'h0);
        queue_empty_in = 1'h1;
        motion_active_in = 1'h1;
        step(2);
        check({io_val_out[0], led_green_out}, 2'h0);
        motion_active_in = 1'h0;
        err_ok_in = 1'h0;
        step(2);
        check({io_val_out[0], led_green_out}, 2'h0);
        io_is_out_in = 3'h4;
        host.send(`SMD_CMD_MON_ON);
        check({cmd_err_out, prog_abort_out}, 2'h3);
        io_is_out_in = 3'h0;
        cmd(`SMD_CMD_MON_ON, 1'h1, 1'h0);
        {enc_z_in, enc_b_in, enc_a_in} = 3'h5;
        step(2);
        check({io_drive_out, io_val_out}, {3'h7, 3'h5});
        diff_out_in = 1'h1;
        step(2);
        check(io_val_out, 3'h2);
        io_bit_line_in = 2'h2;
        io_bit_wr_in = 1'h1;
        step(1);
        io_bit_wr_in = 1'h0;
        check({cmd_err_out, prog_abort_out}, 2'h3);
        step(4);
        check(io_drive_out[2:1], 2'h3);
        cmd(`SMD_CMD_MON_OFF, 1'h1, 1'h0);
        step(2);
        check(io_drive_out[2:1], 2'h0);
        reset_in = 1'h1;
        step(2);
        reset_in = 1'h0;
        check({dual_loop_out, io_drive_out}, 4'h0);
        check({map_active_out, map_count_out}, 4'h1);
        final_report();
    end
endmodule
